/* core/gpb_pkg.sv */
/*
  Constants shared by the pin configuration bank: register indices,
  field positions, reset values and bus widths.
  Assumes a classic Wishbone bus with one register per 32-bit word.
*/
package gpb_pkg;
  // Bus shape
  localparam int WB_ADR_W = 10;
  localparam int WB_DAT_W = 32;
  localparam int IDX_W = 8;
  localparam int NPIN = 7;

  // Word indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_PIN_4_3 = 8'h3e;
  localparam logic [IDX_W-1:0] IDX_PIN_5_0 = 8'h3f;
  localparam logic [IDX_W-1:0] IDX_PIN_5_1 = 8'h40;
  localparam logic [IDX_W-1:0] IDX_PIN_5_2 = 8'h41;
  localparam logic [IDX_W-1:0] IDX_PIN_5_3 = 8'h42;
  localparam logic [IDX_W-1:0] IDX_PIN_5_4 = 8'h43;
  localparam logic [IDX_W-1:0] IDX_PIN_5_5 = 8'h44;
  localparam logic [IDX_W-1:0] IDX_DEV_DIS = 8'h50;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 8'h51;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 8'h52;
  localparam logic [IDX_W-1:0] IDX_PIN_LVL = 8'h53;

  // Pin slots inside the bank
  localparam int P43 = 0;
  localparam int P50 = 1;
  localparam int P51 = 2;
  localparam int P52 = 3;
  localparam int P53 = 4;
  localparam int P54 = 5;
  localparam int P55 = 6;

  // Configuration field positions
  localparam int B_DIR = 0;
  localparam int B_POL = 1;
  localparam int B_ALT = 2;
  localparam int B_FN_HI = 3;
  localparam int B_OD = 7;
  localparam int B_DIS_LOCK = 1;

  // Writable bits; reserved bits are never stored
  localparam logic [7:0] MASK_FN1 = 8'h87;
  localparam logic [7:0] MASK_FN2 = 8'h8f;

  // Reset values
  localparam logic [7:0] RST_CFG = 8'h01;
  localparam logic [7:0] RST_CFG_5_3 = 8'h00;
  localparam logic [7:0] RST_DEV_DIS = 8'h00;

  // Two-bit function codes
  localparam logic [1:0] FN_GPIO = 2'h0;
  localparam logic [1:0] FN_01 = 2'h1;
  localparam logic [1:0] FN_10 = 2'h2;
  localparam logic [1:0] FN_11 = 2'h3;

  // Interrupt status bits
  localparam int IRQ_EDGE3 = 0;
  localparam int IRQ_DIS_REFUSED = 1;
  localparam int IRQ_LOCKED = 2;
  localparam int NIRQ = 3;
endpackage : gpb_pkg

/* core/gpb_sync3.sv */
/*
  Three-stage pin synchroniser with a settle check.
  Assumes an asynchronous pin level; output moves only once the
  second and third stages agree.
*/
`timescale 1ns/1ps
module gpb_sync3 #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic d_i,
  output logic q_o
);
  logic s1_reg; // Metastable stage, read only by s2
  logic s2_reg;
  logic s3_reg;

  // Shift chain
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
      s3_reg <= RST_VAL;
    end else begin
      s1_reg <= d_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Accept a level only when two late stages agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_o <= RST_VAL;
    end else if (s2_reg == s3_reg) begin
      q_o <= s3_reg;
    end
  end
endmodule : gpb_sync3

/* core/gpb_pin_cell.sv */
/*
  One pin's driver and receiver: direction, polarity, driver type.
  Assumes a synchronised pin level; pin output and enable are flopped.
*/
`timescale 1ns/1ps
module gpb_pin_cell (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic dir_in_i,
  input wire logic pol_inv_i,
  input wire logic od_i,
  input wire logic raw_in_i,
  input wire logic alt_out_en_i,
  input wire logic alt_out_i,
  input wire logic gp_out_i,
  input wire logic pin_lvl_i,
  output logic in_val_o,
  output logic pin_o,
  output logic pin_oe_n_o
);
  logic is_in; // Effective direction
  logic drv_val; // Level wanted on the pin

  // Raw mode forces a plain input
  assign is_in = dir_in_i | raw_in_i;
  assign drv_val = (alt_out_en_i ? alt_out_i : gp_out_i) ^ pol_inv_i;
  assign in_val_o = raw_in_i ? pin_lvl_i : (pin_lvl_i ^ pol_inv_i);

  // Driver: open drain only ever pulls low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_o <= 1'b0;
      pin_oe_n_o <= 1'b1;
    end else if (is_in) begin
      pin_o <= 1'b0;
      pin_oe_n_o <= 1'b1;
    end else if (od_i) begin
      pin_o <= 1'b0;
      pin_oe_n_o <= drv_val;
    end else begin
      pin_o <= drv_val;
      pin_oe_n_o <= 1'b0;
    end
  end
endmodule : gpb_pin_cell

/* core/gpb_bank.sv */
/*
  Pin configuration bank for seven general-purpose pins, with
  alternate function routing, a lockable disable-register control
  mode, the disable register itself and an interrupt block.
  Assumes a classic Wishbone master, synchronous active-high resets
  in the clk_i domain, and asynchronous pin levels.
*/
`timescale 1ns/1ps

module gpb_bank
  import gpb_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic main_por_i,
  input wire logic hard_reset_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [WB_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [WB_DAT_W-1:0] wb_dat_i,
  output logic [WB_DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // Pins
  input wire logic [NPIN-1:0] pin_i,
  output logic [NPIN-1:0] pin_o,
  output logic [NPIN-1:0] pin_oe_n_o,
  // Plain data path to and from the data registers
  input wire logic [NPIN-1:0] gpio_out_i,
  output logic [NPIN-1:0] gpio_in_o,
  // Alternate function peers
  input wire logic ext_bus_chip_select_1_i,
  input wire logic port2_request_to_send_i,
  input wire logic infrared_transmit_i,
  input wire logic port2_transmit_data_i,
  output logic port2_ring_indicate_o,
  output logic port2_carrier_detect_o,
  output logic port2_data_set_ready_o,
  output logic infrared_receive_o,
  output logic port2_receive_data_o,
  output logic edge_irq3_o,
  output logic disable_reg_write_control_o,
  output logic [7:0] dev_disable_o,
  output logic irq_o
);
  // Configuration storage, one byte per pin
  logic [7:0] cfg_reg [NPIN];
  logic [7:0] dev_dis_reg; // Device disable register
  logic [NIRQ-1:0] irq_stat_reg; // Sticky events
  logic [NIRQ-1:0] irq_mask_reg; // Enables onto irq_o
  logic [NIRQ-1:0] irq_set; // Events this cycle
  logic ack_reg; // Registered acknowledge
  logic edge_prev_reg; // Last seen pin 4.3 value
  logic lock_prev_reg; // Lock state one cycle back

  // Bus decode
  logic [IDX_W-1:0] idx; // Word index
  logic req; // Live request
  logic wr_go; // Write lands this edge
  logic lane0; // Low byte lane enabled
  logic [7:0] wr_byte; // Write data, low lane

  // Pin side views
  logic [NPIN-1:0] pin_lvl; // Settled pin levels
  logic [NPIN-1:0] in_val; // After polarity
  logic [NPIN-1:0] alt_en; // Alternate output selected
  logic [NPIN-1:0] alt_val; // Alternate output level
  logic [NPIN-1:0] raw_in; // Forced raw input
  logic [1:0] fn43; // Function field of pin 4.3
  logic [1:0] fn52; // Function field of pin 5.2
  logic [1:0] fn53; // Function field of pin 5.3
  logic locked; // Control mode is latched in
  logic dis_writable; // Disable register accepts writes
  logic edge3; // Either-edge event on pin 4.3
  logic [7:0] cfg_mask [NPIN]; // Storable bits per pin
  logic [7:0] rd_byte; // Read mux result

  assign idx = wb_adr_i[WB_ADR_W-1:2];
  assign req = wb_cyc_i & wb_stb_i;
  // Writes act only on the edge where ack is seen high
  assign wr_go = req & ack_reg & wb_we_i;
  assign lane0 = wb_sel_i[0];
  assign wr_byte = wb_dat_i[7:0];

  // Function fields
  assign fn43 = cfg_reg[P43][B_FN_HI:B_ALT];
  assign fn52 = cfg_reg[P52][B_FN_HI:B_ALT];
  assign fn53 = cfg_reg[P53][B_FN_HI:B_ALT];
  assign locked = (fn43 == FN_01);

  // Which bits each pin may store
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      cfg_mask[i] = MASK_FN1;
    end
    cfg_mask[P43] = MASK_FN2;
    cfg_mask[P52] = MASK_FN2;
    cfg_mask[P53] = MASK_FN2;
  end

  // Acknowledge: one wait cycle, then one ack cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end
  assign wb_ack_o = ack_reg;

  // Pin configuration registers, all seven bytes in one process.
  // The bytes share one array, so splitting this process would give
  // the array several drivers; later assignments below take priority.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NPIN; i++) begin
        cfg_reg[i] <= (i == P53) ? RST_CFG_5_3 : RST_CFG;
      end
    end else begin
      for (int i = 0; i < NPIN; i++) begin
        // Reserved bits are dropped on the way in
        if (wr_go && lane0 && idx == IDX_PIN_4_3 + IDX_W'(i)) begin
          cfg_reg[i] <= wr_byte & cfg_mask[i];
        end
      end
      // Once in control mode software cannot leave it
      if (locked) begin
        cfg_reg[P43][B_FN_HI:B_ALT] <= FN_01;
      end
      // Main POR and hard reset: 4.3 function field, all of 5.3
      if (main_por_i || hard_reset_i) begin
        cfg_reg[P43][B_FN_HI:B_ALT] <= FN_GPIO;
        cfg_reg[P53] <= RST_CFG_5_3;
      end
    end
  end

  // Disable register guard while the control mode holds
  always_comb begin
    if (!locked) begin
      dis_writable = 1'b1;
    end else if (pin_lvl[P43]) begin
      dis_writable = 1'b0;
    end else begin
      dis_writable = ~dev_dis_reg[B_DIS_LOCK];
    end
  end

  // Device disable register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dev_dis_reg <= RST_DEV_DIS;
    end else if (wr_go && lane0 && idx == IDX_DEV_DIS && dis_writable) begin
      dev_dis_reg <= wr_byte;
    end
  end
  assign dev_disable_o = dev_dis_reg;
  assign disable_reg_write_control_o = locked;

  // Read mux, all unused bits zero
  always_comb begin
    rd_byte = 8'h00;
    if (idx >= IDX_PIN_4_3 && idx <= IDX_PIN_5_5) begin
      rd_byte = cfg_reg[3'(idx - IDX_PIN_4_3)];
    end else begin
      unique case (idx)
        IDX_DEV_DIS: rd_byte = dev_dis_reg;
        IDX_IRQ_STAT: rd_byte = {5'h00, irq_stat_reg};
        IDX_IRQ_MASK: rd_byte = {5'h00, irq_mask_reg};
        IDX_PIN_LVL: rd_byte = {1'b0, in_val};
        default: rd_byte = 8'h00; // Unmapped reads zero
      endcase
    end
  end

  // Read data is captured as ack rises
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (req && !ack_reg) begin
      wb_dat_o <= {24'h000000, rd_byte};
    end
  end

  // Pin synchronisers; resting level high suits active-low lines
  for (genvar g = 0; g < NPIN; g++) begin : g_pin
    gpb_sync3 #(
      .RST_VAL(1'b1)
    ) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i(pin_i[g]),
      .q_o(pin_lvl[g])
    );

    gpb_pin_cell u_cell (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .dir_in_i(cfg_reg[g][B_DIR]),
      .pol_inv_i(cfg_reg[g][B_POL]),
      .od_i(cfg_reg[g][B_OD]),
      .raw_in_i(raw_in[g]),
      .alt_out_en_i(alt_en[g]),
      .alt_out_i(alt_val[g]),
      .gp_out_i(gpio_out_i[g]),
      .pin_lvl_i(pin_lvl[g]),
      .in_val_o(in_val[g]),
      .pin_o(pin_o[g]),
      .pin_oe_n_o(pin_oe_n_o[g])
    );
  end

  // Only pin 4.3 has a raw mode
  always_comb begin
    raw_in = '0;
    raw_in[P43] = locked;
  end

  // Alternate output selection per pin
  always_comb begin
    alt_en = '0;
    alt_val = '0;
    if (fn43 == FN_10) begin
      alt_en[P43] = 1'b1;
      alt_val[P43] = ext_bus_chip_select_1_i;
    end
    if (cfg_reg[P55][B_ALT]) begin
      alt_en[P55] = 1'b1;
      alt_val[P55] = port2_request_to_send_i;
    end
    // Code 11 is reserved and behaves as plain pin
    if (fn53 == FN_10) begin
      alt_en[P53] = 1'b1;
      alt_val[P53] = infrared_transmit_i;
    end else if (fn53 == FN_01) begin
      alt_en[P53] = 1'b1;
      alt_val[P53] = port2_transmit_data_i;
    end
  end

  // Incoming alternate lines; idle high when not routed
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port2_ring_indicate_o <= 1'b1;
      port2_carrier_detect_o <= 1'b1;
      port2_data_set_ready_o <= 1'b1;
      infrared_receive_o <= 1'b1;
      port2_receive_data_o <= 1'b1;
    end else begin
      port2_ring_indicate_o <= cfg_reg[P50][B_ALT] ? in_val[P50] : 1'b1;
      port2_carrier_detect_o <= cfg_reg[P51][B_ALT] ? in_val[P51] : 1'b1;
      port2_data_set_ready_o <= cfg_reg[P54][B_ALT] ? in_val[P54] : 1'b1;
      infrared_receive_o <= (fn52 == FN_10) ? in_val[P52] : 1'b1;
      port2_receive_data_o <= (fn52 == FN_01) ? in_val[P52] : 1'b1;
    end
  end

  // Plain input view for the data registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gpio_in_o <= '0;
    end else begin
      gpio_in_o <= in_val;
    end
  end

  // Either-edge detector; tracks even when unselected so that
  // selecting the function does not fire on a stale level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      edge_prev_reg <= 1'b1;
      lock_prev_reg <= 1'b0;
    end else begin
      edge_prev_reg <= in_val[P43];
      lock_prev_reg <= locked;
    end
  end
  assign edge3 = (fn43 == FN_11) && (in_val[P43] != edge_prev_reg);

  // One-cycle pulse toward the interrupt router
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      edge_irq3_o <= 1'b0;
    end else begin
      edge_irq3_o <= edge3;
    end
  end

  // Events of this cycle
  always_comb begin
    irq_set = '0;
    irq_set[IRQ_EDGE3] = edge3;
    irq_set[IRQ_DIS_REFUSED] = wr_go & lane0 & (idx == IDX_DEV_DIS) & ~dis_writable;
    irq_set[IRQ_LOCKED] = locked & ~lock_prev_reg;
  end

  // Sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_reg <= '0;
    end else if (wr_go && lane0 && idx == IDX_IRQ_STAT) begin
      irq_stat_reg <= (irq_stat_reg & ~wr_byte[NIRQ-1:0]) | irq_set;
    end else begin
      irq_stat_reg <= irq_stat_reg | irq_set;
    end
  end

  // Mask register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_reg <= '0;
    end else if (wr_go && lane0 && idx == IDX_IRQ_MASK) begin
      irq_mask_reg <= wr_byte[NIRQ-1:0];
    end
  end

  // Level interrupt, follows status one cycle later
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_reg & irq_mask_reg);
    end
  end
endmodule : gpb_bank

/* tb/gpb_checker.sv */
/* Port checker for the pin bank: handshake, lock, guard, pulses.
   Assumes a bind onto gpb_bank, one clock, sync reset rst_i. */
`timescale 1ns/1ps
module gpb_checker
  import gpb_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic main_por_i,
  input wire logic hard_reset_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [WB_ADR_W-1:0] wb_adr_i,
  input wire logic [WB_DAT_W-1:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [NPIN-1:0] pin_oe_n_o,
  input wire logic edge_irq3_o,
  input wire logic disable_reg_write_control_o,
  input wire logic [7:0] dev_disable_o,
  input wire logic irq_o
);
  // One domain, so one clocking and one reset
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Live request and its word index
  logic req;
  logic [IDX_W-1:0] idx;
  logic lock;
  assign req = wb_cyc_i && wb_stb_i;
  assign idx = wb_adr_i[WB_ADR_W-1:2];
  assign lock = disable_reg_write_control_o;

  AST_ACK_NEXT: assert property (req && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  AST_RSVD_ZERO: assert property (
    wb_ack_o && !wb_we_i && idx >= IDX_PIN_4_3 && idx <= IDX_PIN_5_5
    |-> wb_dat_o[31:8] == 24'h0 && wb_dat_o[6:4] == 3'h0)
    else $error("reserved bits not zero");
  AST_CTRL_INPUT: assert property (lock && $past(lock) |-> pin_oe_n_o[P43])
    else $error("control pin driven");
  AST_LOCK_HOLDS: assert property (lock && !main_por_i && !hard_reset_i |=> lock)
    else $error("lock lost");
  AST_POR_CLEARS: assert property (main_por_i || hard_reset_i |=> !lock)
    else $error("lock kept over reset");
  AST_GUARD_LOCK: assert property (lock && dev_disable_o[B_DIS_LOCK] |=> $stable(dev_disable_o))
    else $error("guarded register changed");
  AST_DIS_BY_WRITE: assert property (
    $changed(dev_disable_o) |-> $past(req && wb_we_i && wb_ack_o && idx == IDX_DEV_DIS))
    else $error("disable register changed unasked");
  AST_EDGE_PULSE: assert property (edge_irq3_o |=> !edge_irq3_o)
    else $error("edge pulse too long");
  // Main scenarios reached
  cover property (lock && dev_disable_o[B_DIS_LOCK]);
  cover property (edge_irq3_o);
  cover property (irq_o);
  cover property ($changed(dev_disable_o));
endmodule : gpb_checker

/* tb/gpb_board.sv */
/* Board model on the package pins: pull-ups plus optional drivers.
   Assumes the bench sets drv_en_i and drv_lvl_i after clock edges. */
`timescale 1ns/1ps
module gpb_board
  import gpb_pkg::*;
(
  input wire logic [NPIN-1:0] pin_o,
  input wire logic [NPIN-1:0] pin_oe_n_o,
  input wire logic [NPIN-1:0] drv_en_i,
  input wire logic [NPIN-1:0] drv_lvl_i,
  output logic [NPIN-1:0] pin_lvl_o
);
  // Bank wins when enabled, then the board, else the pull-up
  always_comb begin
    for (int k = 0; k < NPIN; k++) begin
      if (!pin_oe_n_o[k]) pin_lvl_o[k] = pin_o[k];
      else if (drv_en_i[k]) pin_lvl_o[k] = drv_lvl_i[k];
      else pin_lvl_o[k] = 1'b1; // Released line floats high
    end
  end
endmodule : gpb_board

/* tb/gpb_bank_test.sv */
/* Self-checking bench for gpb_bank: registers, routing, lock, irq.
   Assumes the board model in gpb_board and the checker bound below. */
`timescale 1ns/1ps
module gpb_bank_test
  import gpb_pkg::*;
;
  logic clk_i = 1'b0, rst_i = 1'b1, main_por_i = 1'b0, hard_reset_i = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [WB_ADR_W-1:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = 4'hf;
  logic [WB_DAT_W-1:0] wb_dat_i = '0;
  logic [WB_DAT_W-1:0] wb_dat_o;
  logic wb_ack_o, edge_irq3_o, ctl, irq_o;
  logic [NPIN-1:0] pin_i, pin_o, pin_oe_n_o, gpio_in_o;
  logic [NPIN-1:0] gpio_out_i = 7'h7f, drv_en = 7'h00, drv_lvl = 7'h00;
  logic [3:0] alt_src = 4'hf; // Outgoing peers, one low at a time
  logic [4:0] alt_in; // Incoming peers
  logic [7:0] dev_dis;
  int miscompares = 0, samples_checked = 0;

  always #5 clk_i = ~clk_i;

  gpb_board i_board (.pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o), .drv_en_i(drv_en), .drv_lvl_i(drv_lvl),
    .pin_lvl_o(pin_i));
  gpb_bank i_dut (.clk_i, .rst_i, .main_por_i, .hard_reset_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pin_i, .pin_o, .pin_oe_n_o, .gpio_out_i, .gpio_in_o,
    .ext_bus_chip_select_1_i(alt_src[0]), .port2_request_to_send_i(alt_src[1]),
    .infrared_transmit_i(alt_src[2]), .port2_transmit_data_i(alt_src[3]),
    .port2_ring_indicate_o(alt_in[0]), .port2_carrier_detect_o(alt_in[1]),
    .port2_data_set_ready_o(alt_in[2]), .infrared_receive_o(alt_in[3]), .port2_receive_data_o(alt_in[4]),
    .edge_irq3_o, .disable_reg_write_control_o(ctl), .dev_disable_o(dev_dis), .irq_o);

  task report_and_stop;
    $display("Checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  task chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
      miscompares++;
    end
  endtask : chk

  // Classic single cycle; ack and data taken at the same edge
  task wb(input logic w, input logic [7:0] i, input logic [7:0] d, output logic [7:0] q);
    int n;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
    wb_adr_i <= {i, 2'b00};
    wb_dat_i <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o[7:0];
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    if (n >= 20) begin
      miscompares++;
      report_and_stop;
    end
  endtask : wb

  task wr(input logic [7:0] i, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, i, d, q);
  endtask : wr

  task rdc(input logic [7:0] i, input logic [7:0] e);
    logic [7:0] q;
    wb(1'b0, i, 8'h00, q);
    chk(q, e);
  endtask : rdc

  // Drive a pin low from the board, expect it on an incoming peer
  task in_route(input logic [7:0] i, input logic [7:0] c, input int s, input int b);
    wr(i, c);
    drv_en[s] <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk({7'h0, alt_in[b]}, 8'h00);
    drv_en[s] <= 1'b0;
  endtask : in_route

  // Only peer k is low, so a wrong select shows a high pin
  task out_route(input logic [7:0] i, input logic [7:0] c, input int s, input int k);
    alt_src <= ~(4'h1 << k);
    wr(i, c);
    repeat (3) @(posedge clk_i);
    chk({6'h0, pin_o[s], pin_oe_n_o[s]}, 8'h00);
  endtask : out_route

  // Reset values, reserved bits, unmapped word, driver modes
  task t_regs;
    rdc(IDX_PIN_LVL, 8'h7f);
    for (int k = 0; k < NPIN; k++) rdc(IDX_PIN_4_3 + 8'(k), k == P53 ? RST_CFG_5_3 : RST_CFG);
    wr(IDX_PIN_5_0, 8'hff);
    rdc(IDX_PIN_5_0, MASK_FN1);
    wr(IDX_PIN_5_2, 8'hff);
    rdc(IDX_PIN_5_2, MASK_FN2);
    wr(8'h60, 8'h5a);
    rdc(8'h60, 8'h00);
    wr(IDX_PIN_5_0, 8'h00);
    repeat (2) @(posedge clk_i);
    chk({6'h0, pin_o[P50], pin_oe_n_o[P50]}, 8'h02);
    wr(IDX_PIN_5_0, 8'h02);
    repeat (2) @(posedge clk_i);
    chk({6'h0, pin_o[P50], pin_oe_n_o[P50]}, 8'h00);
    wr(IDX_PIN_5_0, 8'h80);
    repeat (2) @(posedge clk_i);
    chk({6'h0, pin_o[P50], pin_oe_n_o[P50]}, 8'h01);
    wr(IDX_PIN_5_0, 8'h03);
    drv_en[P50] <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk({6'h0, gpio_in_o[P50], pin_oe_n_o[P50]}, 8'h03);
    drv_en[P50] <= 1'b0;
  endtask : t_regs

  // Edge interrupt raised, masked and cleared
  task t_irq;
    int n;
    wr(IDX_IRQ_MASK, 8'h01);
    wr(IDX_PIN_4_3, 8'h0d);
    repeat (8) @(posedge clk_i);
    wr(IDX_IRQ_STAT, 8'h07);
    drv_en[P43] <= 1'b1;
    n = 0;
    while (edge_irq3_o !== 1'b1 && n < 12) begin
      @(posedge clk_i);
      n++;
    end
    chk({7'h0, edge_irq3_o}, 8'h01);
    repeat (3) @(posedge clk_i);
    chk({7'h0, irq_o}, 8'h01);
    wr(IDX_IRQ_MASK, 8'h00);
    repeat (3) @(posedge clk_i);
    chk({7'h0, irq_o}, 8'h00);
    rdc(IDX_IRQ_STAT, 8'h01);
    drv_en[P43] <= 1'b0;
    repeat (8) @(posedge clk_i);
    wr(IDX_IRQ_STAT, 8'h07);
    rdc(IDX_IRQ_STAT, 8'h00);
  endtask : t_irq

  // Control mode: forced input, guard, lock and its release
  task t_lock;
    wr(IDX_PIN_5_3, 8'h81);
    wr(IDX_PIN_4_3, 8'h06);
    drv_lvl[P43] <= 1'b1;
    drv_en[P43] <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk({6'h0, gpio_in_o[P43], pin_oe_n_o[P43]}, 8'h03);
    chk({7'h0, ctl}, 8'h01);
    wr(IDX_DEV_DIS, 8'h55);
    rdc(IDX_DEV_DIS, 8'h00);
    drv_lvl[P43] <= 1'b0;
    repeat (8) @(posedge clk_i);
    wr(IDX_DEV_DIS, 8'h02);
    rdc(IDX_DEV_DIS, 8'h02);
    wr(IDX_DEV_DIS, 8'h10);
    rdc(IDX_DEV_DIS, 8'h02);
    chk(dev_dis, 8'h02);
    wr(IDX_PIN_4_3, 8'h00);
    rdc(IDX_PIN_4_3, 8'h04);
    rdc(IDX_IRQ_STAT, 8'h06);
    main_por_i <= 1'b1;
    @(posedge clk_i);
    main_por_i <= 1'b0;
    rdc(IDX_PIN_4_3, 8'h00);
    rdc(IDX_PIN_5_3, 8'h00);
    chk({7'h0, ctl}, 8'h00);
    wr(IDX_PIN_4_3, 8'h04);
    hard_reset_i <= 1'b1;
    @(posedge clk_i);
    hard_reset_i <= 1'b0;
    rdc(IDX_PIN_4_3, 8'h00);
  endtask : t_lock

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    in_route(IDX_PIN_5_0, 8'h05, P50, 0);
    in_route(IDX_PIN_5_1, 8'h05, P51, 1);
    in_route(IDX_PIN_5_4, 8'h05, P54, 2);
    in_route(IDX_PIN_5_2, 8'h09, P52, 3);
    in_route(IDX_PIN_5_2, 8'h05, P52, 4);
    out_route(IDX_PIN_4_3, 8'h08, P43, 0);
    out_route(IDX_PIN_5_5, 8'h04, P55, 1);
    out_route(IDX_PIN_5_3, 8'h08, P53, 2);
    out_route(IDX_PIN_5_3, 8'h04, P53, 3);
    t_irq;
    t_lock;
    report_and_stop;
  end

  // Cuts a hang short
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    report_and_stop;
  end
endmodule : gpb_bank_test

bind gpb_bank gpb_checker i_chk (.clk_i, .rst_i, .main_por_i, .hard_reset_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_o, .wb_ack_o, .pin_oe_n_o, .edge_irq3_o, .disable_reg_write_control_o, .dev_disable_o,
  .irq_o);
